// file: verilog/smp_power_ctrl.sv
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module smp_power_ctrl #(
	parameter logic [31:0] MIN_CYCLES = smp_pkg::IDLE_MIN_CYC,   // one-minute tick length
	parameter logic [31:0] MS_CYCLES  = smp_pkg::IDLE_MS_CYC     // one-millisecond tick length
) (
	input  wire logic                 i_clock,          // system clock
	input  wire logic                 i_sys_rst,        // async reset, high
	input  wire smp_pkg::smp_bus_t    i_bus,            // register request
	input  wire smp_pkg::smp_events_t i_events,         // event sources
	output logic [15:0]               o_rdata,          // read data, cycle after read
	output logic                      o_smi_n,          // system management interrupt, low
	output logic                      o_stop_clock_n,   // stop-clock to processor, low
	output logic                      o_irq             // local interrupt, high
);

	// ****************************************************************
	// register storage
	// ****************************************************************
	logic [7:0]                  ctrl_reg;
	logic [15:0]                 src_en_reg;
	logic [7:0]                  idle_cnt_reg;
	logic [smp_pkg::NUM_EV-1:0]  flags_reg;
	logic [smp_pkg::NUM_EV-1:0]  flags_next;
	logic [smp_pkg::NUM_EV-1:0]  ev_prev_reg;
	logic [smp_pkg::NUM_EV-1:0]  ev_now;
	logic [smp_pkg::NUM_EV-1:0]  ev_rise;
	logic [smp_pkg::NUM_EV-1:0]  ev_set;
	logic [7:0]                  stp_high_reg;
	logic [7:0]                  stp_low_reg;
	logic [smp_pkg::NUM_IRQ-1:0] irq_stat_reg;
	logic [smp_pkg::NUM_IRQ-1:0] irq_mask_reg;
	logic [smp_pkg::NUM_IRQ-1:0] irq_set;
	logic [31:0]                 pre_reg;
	logic [8:0]                  tmr_reg;
	logic [8:0]                  tmr_load;
	logic                        tmr_tick;
	logic                        tmr_event;
	logic [7:0]                  stp_cnt_reg;
	logic                        smi_prev_reg;
	logic                        stp_prev_reg;
	smp_pkg::smp_stp_state_t     stp_state_reg;

	// decoded write and read strobes
	logic wr_ctrl;
	logic wr_src;
	logic wr_idle;
	logic wr_flags;
	logic rd_irq;
	logic [1:0] tmr_field;
	logic       gate_on;
	logic       stp_en;
	logic       scale_on;

	assign wr_ctrl  = i_bus.wr && (i_bus.addr == smp_pkg::OFS_CTRL);
	assign wr_src   = i_bus.wr && (i_bus.addr == smp_pkg::OFS_SRC_EN);
	assign wr_idle  = i_bus.wr && (i_bus.addr == smp_pkg::OFS_IDLE_CNT);
	assign wr_flags = i_bus.wr && (i_bus.addr == smp_pkg::OFS_FLAGS);
	assign rd_irq   = i_bus.rd && (i_bus.addr == smp_pkg::OFS_IRQ_STAT);

	// control fields
	assign tmr_field = ctrl_reg[smp_pkg::CTL_FIELD_LSB +: 2];
	assign gate_on   = ctrl_reg[smp_pkg::CTL_GATE_BIT];
	assign stp_en    = ctrl_reg[smp_pkg::CTL_STP_BIT];
	assign scale_on  = ctrl_reg[smp_pkg::CTL_SCALE_BIT];

	// ****************************************************************
	// software registers
	// ****************************************************************
	// control and source enable; reserved bits never stored
	// control reset value
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ctrl_reg   <= smp_pkg::CTRL_RST;
			src_en_reg <= smp_pkg::SRC_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= i_bus.wdata[7:0] & smp_pkg::CTRL_WMASK;
			if (wr_src)
				src_en_reg <= i_bus.wdata & smp_pkg::SRC_WMASK;
		end
	end

	// idle reload value and stop-clock phase lengths
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			idle_cnt_reg <= smp_pkg::IDLE_CNT_RST;
			stp_high_reg <= smp_pkg::STP_HIGH_RST;
			stp_low_reg  <= smp_pkg::STP_LOW_RST;
		end
		else if (i_bus.wr)
		begin
			if (i_bus.addr == smp_pkg::OFS_IDLE_CNT)
				idle_cnt_reg <= i_bus.wdata[7:0];
			if (i_bus.addr == smp_pkg::OFS_STP_HIGH)
				stp_high_reg <= i_bus.wdata[7:0];
			if (i_bus.addr == smp_pkg::OFS_STP_LOW)
				stp_low_reg <= i_bus.wdata[7:0];
		end
	end

	// ****************************************************************
	// idle timer
	// ****************************************************************
	// granularity select
	assign tmr_tick = (tmr_field == smp_pkg::TMR_CLOCK) ||
		((tmr_field == smp_pkg::TMR_MSEC) && (pre_reg == MS_CYCLES - 32'h0000_0001)) ||
		((tmr_field == smp_pkg::TMR_MINUTE) && (pre_reg == MIN_CYCLES - 32'h0000_0001));
	assign tmr_event = tmr_tick && (tmr_field != smp_pkg::TMR_STOP) && (tmr_reg == 9'h001);
	assign tmr_load  = {1'b0, idle_cnt_reg} + 9'h001;

	// prescaler; restarts when stopped so a new granularity starts clean
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			pre_reg <= 32'h0000_0000;
		else if ((tmr_field == smp_pkg::TMR_STOP) || tmr_tick)
			pre_reg <= 32'h0000_0000;
		else
			pre_reg <= pre_reg + 32'h0000_0001;
	end

	// countdown; a value write reloads at once, software stops it first
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			tmr_reg <= 9'h010;
		else if (wr_idle)
			tmr_reg <= {1'b0, i_bus.wdata[7:0]} + 9'h001;
		else if (tmr_field == smp_pkg::TMR_STOP)
			tmr_reg <= tmr_load;
		else if (tmr_event)
			tmr_reg <= tmr_load;
		else if (tmr_tick)
			tmr_reg <= tmr_reg - 9'h001;
	end

	// ****************************************************************
	// event detection and status flags
	// ****************************************************************
	// usb legacy at bit 8
	assign ev_now = {i_events.usb_legacy, i_events.apm_write, ~i_events.ext_req_n, tmr_event,
		i_events.irq12, i_events.irq8, i_events.irq4, i_events.irq3, i_events.irq1};
	// edge gives one flag per activation
	assign ev_rise = ev_now & ~ev_prev_reg;
	assign ev_set  = ev_rise & src_en_reg[smp_pkg::NUM_EV-1:0];

	// writing zero clears a flag, but a same-cycle set wins
	always_comb
	begin
		flags_next = flags_reg;
		if (wr_flags)
			flags_next = flags_reg & i_bus.wdata[smp_pkg::NUM_EV-1:0];
		flags_next = flags_next | ev_set;
	end

	// previous event levels
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ev_prev_reg <= '0;
		else
			ev_prev_reg <= ev_now;
	end

	// flag storage
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			flags_reg <= '0;
		else
			flags_reg <= flags_next;
	end

	// ****************************************************************
	// interrupt output to the processor
	// ****************************************************************
	// gate masks the pin
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_smi_n <= 1'b1;
		else
			o_smi_n <= ~(gate_on && (|flags_reg));
	end

	// ****************************************************************
	// stop-clock sequencer
	// ****************************************************************
	// state and phase counter; counter only runs while scaling
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			stp_state_reg <= smp_pkg::STP_OFF;
			stp_cnt_reg   <= 8'h00;
		end
		else
		begin
			case (stp_state_reg)
				smp_pkg::STP_OFF:
				begin
					if (stp_en && i_events.apm_read)
					begin
						stp_state_reg <= smp_pkg::STP_LOW;
						stp_cnt_reg   <= stp_low_reg;
					end
				end
				smp_pkg::STP_LOW:
				begin
					if (!stp_en)
						stp_state_reg <= smp_pkg::STP_OFF;
					else if (scale_on && (stp_cnt_reg == 8'h00))
					begin
						stp_state_reg <= smp_pkg::STP_HIGH;
						stp_cnt_reg   <= stp_high_reg;
					end
					else if (scale_on)
						stp_cnt_reg <= stp_cnt_reg - 8'h01;
				end
				smp_pkg::STP_HIGH:
				begin
					if (!stp_en)
						stp_state_reg <= smp_pkg::STP_OFF;
					else if (!scale_on || (stp_cnt_reg == 8'h00))
					begin
						stp_state_reg <= smp_pkg::STP_LOW;
						stp_cnt_reg   <= stp_low_reg;
					end
					else
						stp_cnt_reg <= stp_cnt_reg - 8'h01;
				end
				default:
					stp_state_reg <= smp_pkg::STP_OFF;
			endcase
		end
	end

	// pin low only in the low phase
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_stop_clock_n <= 1'b1;
		else
			o_stop_clock_n <= (stp_state_reg != smp_pkg::STP_LOW);
	end

	// ****************************************************************
	// local interrupt: sticky status, read clears, mask gates
	// ****************************************************************
	assign irq_set = {tmr_event, (!o_stop_clock_n && stp_prev_reg), (!o_smi_n && smi_prev_reg)};

	// previous pin levels for assertion edges
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			smi_prev_reg <= 1'b1;
			stp_prev_reg <= 1'b1;
		end
		else
		begin
			smi_prev_reg <= o_smi_n;
			stp_prev_reg <= o_stop_clock_n;
		end
	end

	// status and mask; a set in the clearing read survives
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end
		else
		begin
			irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) | irq_set;
			if (i_bus.wr && (i_bus.addr == smp_pkg::OFS_IRQ_MASK))
				irq_mask_reg <= i_bus.wdata[smp_pkg::NUM_IRQ-1:0];
		end
	end

	// level output
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat_reg & irq_mask_reg);
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	// unmapped offsets and idle cycles return zero
	// reserved bits read zero
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_rdata <= 16'h0000;
		else if (!i_bus.rd)
			o_rdata <= 16'h0000;
		else
		begin
			case (i_bus.addr)
				smp_pkg::OFS_CTRL:     o_rdata <= {8'h00, ctrl_reg};
				smp_pkg::OFS_SRC_EN:   o_rdata <= src_en_reg;
				smp_pkg::OFS_IDLE_CNT: o_rdata <= {8'h00, idle_cnt_reg};
				smp_pkg::OFS_FLAGS:    o_rdata <= {7'h00, flags_reg};
				smp_pkg::OFS_STP_HIGH: o_rdata <= {8'h00, stp_high_reg};
				smp_pkg::OFS_STP_LOW:  o_rdata <= {8'h00, stp_low_reg};
				smp_pkg::OFS_IRQ_STAT: o_rdata <= {13'h0000, irq_stat_reg};
				smp_pkg::OFS_IRQ_MASK: o_rdata <= {13'h0000, irq_mask_reg};
				default:               o_rdata <= 16'h0000;
			endcase
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	AST_SMI_GATED: assert property (!gate_on |=> o_smi_n)
		else $error("interrupt output asserted with gate clear");
	AST_SMI_PENDING: assert property ((gate_on && (|flags_reg)) |=> !o_smi_n)
		else $error("pending flag did not assert interrupt output");
	AST_EVENT_SMI: assert property ((gate_on && (|ev_set) && !wr_ctrl) |=> ##1 !o_smi_n)
		else $error("enabled event did not reach interrupt output in two cycles");
	AST_FLAG_ONCE: assert property ((flags_reg == '0) && (ev_set == '0) |=> flags_reg == '0)
		else $error("flag set without an enabled rising event");
	AST_SET_WINS: assert property ((|ev_set) |=> |(flags_reg & $past(ev_set)))
		else $error("flag set lost against clear");
	AST_RESERVED: assert property ((ctrl_reg[7:5] == 3'h0) && (src_en_reg[15:9] == 7'h00))
		else $error("reserved bit stored");
	AST_TMR_STOP: assert property ((tmr_field == smp_pkg::TMR_STOP) && !wr_idle && !wr_ctrl
		|=> !tmr_event && (tmr_reg == {1'b0, $past(idle_cnt_reg)} + 9'h001))
		else $error("stopped idle timer moved or expired");
	AST_TMR_RELOAD: assert property ((tmr_event && !wr_idle) |=> tmr_reg == $past(tmr_load))
		else $error("idle timer did not reload value plus one");
	AST_TMR_CLOCK: assert property ((tmr_field == smp_pkg::TMR_CLOCK) && (tmr_reg == 9'h002) && !wr_idle
		&& !wr_ctrl |=> tmr_event)
		else $error("clock granularity did not count every cycle");
	AST_STP_ASSERT: assert property ((stp_state_reg == smp_pkg::STP_OFF) && stp_en && i_events.apm_read
		|=> ##1 !o_stop_clock_n)
		else $error("command read did not assert stop-clock");
	AST_STP_CLEAR: assert property (!stp_en |=> ##1 o_stop_clock_n)
		else $error("stop-clock held after enable cleared");
	AST_STP_SCALE: assert property ((stp_state_reg == smp_pkg::STP_HIGH) && stp_en && scale_on
		&& (stp_cnt_reg != 8'h00) |=> ##1 o_stop_clock_n)
		else $error("stop-clock low during scaled high phase");
	CVR_SMI: cover property (gate_on ##1 !o_smi_n);
	CVR_TMR: cover property (tmr_event && src_en_reg[smp_pkg::EV_TIMER]);
	CVR_SCALE: cover property ((stp_state_reg == smp_pkg::STP_HIGH) ##1 (stp_state_reg == smp_pkg::STP_LOW));
	CVR_IRQ: cover property (o_irq ##1 rd_irq);
endmodule

// file: common/smp_pkg.sv
// ****************************************************************
// power-management control constants and carriers
// ****************************************************************
package smp_pkg;

	// clock rate of the register-side clock
	localparam longint unsigned CLK_HZ        = 64'd50_000_000;
	// idle-timer granularities in their own units
	localparam longint unsigned IDLE_MIN_S    = 64'd60;
	localparam longint unsigned IDLE_MS_US    = 64'd1000;
	localparam logic [31:0]     IDLE_MIN_CYC  = 32'(IDLE_MIN_S * CLK_HZ);
	localparam logic [31:0]     IDLE_MS_CYC   = 32'((IDLE_MS_US * CLK_HZ) / 64'd1_000_000);

	// register offsets on the plain register port
	localparam logic [7:0]  OFS_CTRL      = 8'hA0;
	localparam logic [7:0]  OFS_SRC_EN    = 8'hA2;
	localparam logic [7:0]  OFS_IDLE_CNT  = 8'hA8;
	localparam logic [7:0]  OFS_FLAGS     = 8'hAA;
	localparam logic [7:0]  OFS_STP_HIGH  = 8'hAC;
	localparam logic [7:0]  OFS_STP_LOW   = 8'hAD;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'hB0;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'hB1;

	// control register fields
	localparam int          CTL_GATE_BIT  = 0;
	localparam int          CTL_STP_BIT   = 1;
	localparam int          CTL_SCALE_BIT = 2;
	localparam int          CTL_FIELD_LSB = 3;
	localparam logic [1:0]  TMR_MINUTE    = 2'h0;
	localparam logic [1:0]  TMR_STOP      = 2'h1;
	localparam logic [1:0]  TMR_CLOCK     = 2'h2;
	localparam logic [1:0]  TMR_MSEC      = 2'h3;

	// reset values and writable masks
	localparam logic [7:0]  CTRL_RST      = 8'h08;
	localparam logic [7:0]  CTRL_WMASK    = 8'h1F;
	localparam logic [15:0] SRC_RST       = 16'h0000;
	localparam logic [15:0] SRC_WMASK     = 16'h01FF;
	localparam logic [7:0]  IDLE_CNT_RST  = 8'h0F;
	localparam logic [7:0]  STP_HIGH_RST  = 8'h0F;
	localparam logic [7:0]  STP_LOW_RST   = 8'h0F;

	// event source positions, shared by enable and flag registers
	localparam int          NUM_EV        = 9;
	localparam int          EV_TIMER      = 5;

	// interrupt status bits
	localparam int          NUM_IRQ       = 3;
	localparam int          IRQ_SMI_BIT   = 0;
	localparam int          IRQ_STP_BIT   = 1;
	localparam int          IRQ_TMR_BIT   = 2;

	// register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} smp_bus_t;

	// event inputs
	typedef struct packed {
		logic usb_legacy;
		logic apm_write;
		logic apm_read;
		logic ext_req_n;
		logic irq12;
		logic irq8;
		logic irq4;
		logic irq3;
		logic irq1;
	} smp_events_t;

	// stop-clock sequencer
	typedef enum logic [1:0] {
		STP_OFF  = 2'b00,
		STP_LOW  = 2'b01,
		STP_HIGH = 2'b10
	} smp_stp_state_t;

endpackage

// file: dv/smp_host_model.sv
`timescale 1ns/10ps
// ****************************************************************
// host processor model: watches interrupt and stop-clock pins
// ****************************************************************
module smp_host_model (
	input  wire logic        i_clock,         // system clock
	input  wire logic        i_sys_rst,       // async reset, high
	input  wire logic        i_smi_n,         // interrupt pin, low
	input  wire logic        i_stop_clock_n,  // stop-clock pin, low
	output logic [31:0]      o_smi_gap,       // cycles between last two falls
	output logic [31:0]      o_low_len,       // last low phase length
	output logic [31:0]      o_high_len       // last high phase length
);
	logic [31:0] cyc_reg;
	logic [31:0] last_fall_reg;
	logic        smi_d_reg;
	logic        stp_d_reg;
	logic [31:0] run_reg;

	// interrupt fall spacing; the host registers the pin once and detects its falls
	// expiry spacing seen
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cyc_reg       <= 32'h0;
			last_fall_reg <= 32'h0;
			smi_d_reg     <= 1'b1;
			o_smi_gap     <= 32'h0;
		end
		else
		begin
			cyc_reg   <= cyc_reg + 32'h1;
			smi_d_reg <= i_smi_n;
			if (smi_d_reg && !i_smi_n)
			begin
				o_smi_gap     <= cyc_reg - last_fall_reg;
				last_fall_reg <= cyc_reg;
			end
		end
	end

	// stop-clock phase lengths, in whole cycles
	// phase length capture
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			stp_d_reg  <= 1'b1;
			run_reg    <= 32'h0;
			o_low_len  <= 32'h0;
			o_high_len <= 32'h0;
		end
		else
		begin
			stp_d_reg <= i_stop_clock_n;
			if (stp_d_reg != i_stop_clock_n)
			begin
				run_reg <= 32'h1;
				if (stp_d_reg)
					o_high_len <= run_reg;
				else
					o_low_len <= run_reg;
			end
			else
				run_reg <= run_reg + 32'h1;
		end
	end
endmodule

// file: dv/smp_power_ctrl_bench.sv
`timescale 1ns/10ps
// ****************************************************************
// bench for the power-management control block
// ****************************************************************
module smp_power_ctrl_bench;
	// short tick lengths keep the run brief
	localparam logic [31:0] T_MIN = 32'h14;
	localparam logic [31:0] T_MS  = 32'h5;

	logic              i_clock;
	logic              i_sys_rst;
	smp_pkg::smp_bus_t bus;
	logic [8:0]        ev;
	logic [15:0]       rdata;
	logic              smi_n;
	logic              stop_clock_n;
	logic              irq;
	logic [31:0]       smi_gap;
	logic [31:0]       low_len;
	logic [31:0]       high_len;
	logic [15:0]       rd_val;
	int                miscompares;
	int                check_count;
	int                cycles;
	logic [7:0]        tm_ctl [3] = '{8'h11, 8'h19, 8'h01};
	logic [15:0]       tm_val [3] = '{16'h14, 16'h03, 16'h01};
	logic [31:0]       tm_gap [3] = '{32'h15, 32'h14, 32'h28};

	smp_power_ctrl #(.MIN_CYCLES(T_MIN), .MS_CYCLES(T_MS)) smp_power_ctrl_inst (
		.i_clock        (i_clock),
		.i_sys_rst      (i_sys_rst),
		.i_bus          (bus),
		.i_events       (smp_pkg::smp_events_t'(ev)),
		.o_rdata        (rdata),
		.o_smi_n        (smi_n),
		.o_stop_clock_n (stop_clock_n),
		.o_irq          (irq)
	);

	smp_host_model smp_host_model_inst (
		.i_clock        (i_clock),
		.i_sys_rst      (i_sys_rst),
		.i_smi_n        (smi_n),
		.i_stop_clock_n (stop_clock_n),
		.o_smi_gap      (smi_gap),
		.o_low_len      (low_len),
		.o_high_len     (high_len)
	);

	// 50 MHz clock
	initial i_clock = 1'b0;
	always #10 i_clock = ~i_clock;

	// hang guard, generous against the under one thousand cycles needed
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			complete_run();
		end
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge i_clock);
		bus <= '0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a);
		@(posedge i_clock);
		bus <= '{1'b0, 1'b1, a, 16'h0};
		@(posedge i_clock);
		bus <= '0;
		#1 rd_val = rdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	// one activation: leave idle for a cycle, then back
	task automatic pulse_pos(input int pos, input logic idle);
		@(posedge i_clock);
		ev[pos] <= ~idle;
		@(posedge i_clock);
		ev[pos] <= idle;
	endtask

	// external request sits at bit 5 and is active low
	task automatic pulse_src(input int i);
		pulse_pos((i == 6) ? 5 : i, i == 6);
	endtask

	task automatic wait_smi(input logic lvl);
		int n;
		n = 0;
		while (smi_n !== lvl && n < 300)
		begin
			@(posedge i_clock);
			#1;
			n++;
		end
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs();
		reg_rd(8'hA0);
		chk_val(rd_val, 32'h08);
		reg_rd(8'hA2);
		chk_val(rd_val, 32'h0);
		reg_rd(8'hB4);
		chk_val(rd_val, 32'h0);
		reg_wr(8'hA0, 16'hFFFF);
		reg_rd(8'hA0);
		chk_val(rd_val, 32'h1F);
		reg_wr(8'hA0, 16'h0009);
		reg_wr(8'hA2, 16'hFFFF);
		reg_rd(8'hA2);
		chk_val(rd_val, 32'h1FF);
		reg_wr(8'hA2, 16'h0000);
	endtask

	// each source except the timer alone, then every other non-timer source enabled but this one
	task automatic t_sources();
		for (int i = 0; i < 9; i++)
		begin
			if (i != 5)
			begin
				reg_wr(8'hA0, 16'h0009);
				reg_wr(8'hA2, 16'h1 << i);
				pulse_src(i);
				wait_smi(1'b0);
				chk_val(smi_n, 1'b0);
				reg_rd(8'hAA);
				chk_val(rd_val, 32'h1 << i);
				reg_wr(8'hAA, 16'h0000);
				wait_smi(1'b1);
				chk_val(smi_n, 1'b1);
				reg_wr(8'hA2, 16'h1DF & ~(16'h1 << i));
				pulse_src(i);
				cyc(3);
				reg_rd(8'hAA);
				chk_val(rd_val, 32'h0);
			end
		end
	endtask

	task automatic t_gate();
		reg_wr(8'hA0, 16'h0008);
		reg_wr(8'hA2, 16'h0001);
		pulse_pos(0, 1'b0);
		@(posedge i_clock);
		ev[0] <= 1'b1;
		cyc(4);
		chk_val(smi_n, 1'b1);
		reg_rd(8'hAA);
		chk_val(rd_val, 32'h1);
		reg_wr(8'hA0, 16'h0009);
		wait_smi(1'b0);
		chk_val(smi_n, 1'b0);
		reg_wr(8'hAA, 16'h0000);
		cyc(4);
		reg_rd(8'hAA);
		chk_val(rd_val, 32'h0);
		chk_val(smi_n, 1'b1);
		@(posedge i_clock);
		ev[0] <= 1'b0;
	endtask

	// spacing of expiries for each running granularity
	task automatic t_timer();
		reg_wr(8'hA0, 16'h0009);
		reg_wr(8'hA2, 16'h0020);
		for (int k = 0; k < 3; k++)
		begin
			reg_wr(8'hA8, tm_val[k]);
			reg_wr(8'hA0, {8'h00, tm_ctl[k]});
			wait_smi(1'b0);
			reg_wr(8'hAA, 16'h0000);
			wait_smi(1'b1);
			wait_smi(1'b0);
			// host logs a fall one cycle after the pin drops
			cyc(1);
			chk_val(smi_gap, tm_gap[k]);
			reg_wr(8'hA0, 16'h0009);
			reg_wr(8'hAA, 16'h0000);
			wait_smi(1'b1);
		end
		cyc(60);
		reg_rd(8'hAA);
		chk_val(rd_val, 32'h0);
	endtask

	task automatic t_stop();
		reg_wr(8'hA0, 16'h0009);
		pulse_pos(6, 1'b0);
		cyc(4);
		chk_val(stop_clock_n, 1'b1);
		reg_wr(8'hA0, 16'h000B);
		pulse_pos(6, 1'b0);
		cyc(3);
		chk_val(stop_clock_n, 1'b0);
		cyc(10);
		chk_val(stop_clock_n, 1'b0);
		reg_wr(8'hA0, 16'h0009);
		cyc(4);
		chk_val(stop_clock_n, 1'b1);
		reg_wr(8'hAC, 16'h0002);
		reg_wr(8'hAD, 16'h0003);
		reg_wr(8'hA0, 16'h000F);
		pulse_pos(6, 1'b0);
		cyc(40);
		chk_val(high_len, 32'h3);
		chk_val(low_len, 32'h4);
		reg_wr(8'hA0, 16'h0009);
		cyc(20);
		chk_val(stop_clock_n, 1'b1);
	endtask

	// local interrupt: masked raise, read-to-clear, then masked off
	task automatic t_irq();
		reg_wr(8'hA2, 16'h0001);
		reg_wr(8'hB1, 16'h0001);
		reg_rd(8'hB0);
		pulse_src(0);
		wait_smi(1'b0);
		cyc(2);
		chk_val(irq, 1'b1);
		reg_rd(8'hB0);
		chk_val(rd_val, 32'h1);
		cyc(2);
		chk_val(irq, 1'b0);
		reg_wr(8'hAA, 16'h0000);
		reg_wr(8'hB1, 16'h0000);
		wait_smi(1'b1);
		pulse_src(0);
		wait_smi(1'b0);
		cyc(2);
		chk_val(irq, 1'b0);
		reg_wr(8'hAA, 16'h0000);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		i_sys_rst   = 1'b1;
		bus         = '0;
		ev          = 9'h020;
		miscompares = 0;
		check_count = 0;
		cycles      = 0;
		repeat (20) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		t_regs();
		t_sources();
		t_gate();
		t_timer();
		t_stop();
		t_irq();
		complete_run();
	end
endmodule
